/* File: design/wake_pkg.sv */
// Constants shared by the wake-up receiver reset and standby control.
// Assumes a single sys_clk domain; carrier arrives as a demodulated level.
package wake_pkg;
    localparam int unsigned PREAMBLE_PERIODS = 192;
    localparam int unsigned GAIN_W           = 4;
    localparam logic [3:0]  GAIN_MAX         = 4'hF;
    localparam int unsigned UP_PERIODS       = 8;
    localparam int unsigned DOWN_PERIODS     = 2;
    typedef enum logic [1:0] {
        ST_LISTEN,
        ST_ACTIVE,
        ST_AWAKE
    } mode_e;
endpackage

/* File: design/wake_ctrl.sv */
// Reset, standby listen and wake-up control of a carrier wake-up receiver.
// Assumes carrier, amplitude and period ticks arrive from other domains.
// Assumes reset pin and supply-good act asynchronously on all state.
// Release of reset is synchronised, so logic restarts on a clean edge.
//
// Function
// - Reset from power-on or reset pin
// - Reset clears counters, enters standby listen
// - Power-on reset held while supply low
// - Awake state leaves only through reset
// - Held reset keeps device powered down
// - Standby: regulation off, gain maximum
// - Standby: both active-low outputs high
// - 192 unbroken periods validate preamble, start regulation
// - First gap after preamble: wake low, data on
// - Wake stays low until reset
// - Awake: data output follows carrier presence
`timescale 1ns/1ns
`default_nettype none
module wake_ctrl
    import wake_pkg::*;
#(
    parameter int unsigned PREAMBLE_LEN = PREAMBLE_PERIODS
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              supply_good,
    input  wire logic              carrier_in,
    input  wire logic              period_tick,
    input  wire logic              amp_above_ref,
    output var  logic              data_n,
    output var  logic              wake_request_out_n,
    output var  logic              gain_regulator_en,
    output var  logic [GAIN_W-1:0] gain_step,
    output var  logic              power_down
);
    // Counter widths and stage counts of the local logic
    localparam int unsigned PRE_W    = 16;
    localparam int unsigned UP_W     = 4;
    localparam int unsigned DN_W     = 2;
    localparam int unsigned SYNC_LEN = 2;
    localparam int unsigned REL_LEN  = 3;

    // Terminal counts, one below the number of periods counted
    localparam logic [PRE_W-1:0]  PRE_LAST  = PRE_W'(PREAMBLE_LEN - 1);
    localparam logic [UP_W-1:0]   UP_LAST   = UP_W'(UP_PERIODS - 1);
    localparam logic [DN_W-1:0]   DN_LAST   = DN_W'(DOWN_PERIODS - 1);

    // Counter and gain increments, sized to their targets
    localparam logic [PRE_W-1:0]  PRE_STEP  = PRE_W'(1);
    localparam logic [UP_W-1:0]   UP_STEP   = UP_W'(1);
    localparam logic [DN_W-1:0]   DN_STEP   = DN_W'(1);
    localparam logic [GAIN_W-1:0] GAIN_STEP = GAIN_W'(1);
    localparam logic [GAIN_W-1:0] GAIN_MIN  = '0;

    // Refuse counts that the counters cannot hold
    if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > (1 << PRE_W)) begin : g_bad_pre
        $error("PREAMBLE_LEN does not fit the preamble counter");
    end
    if (UP_PERIODS < 1 || UP_PERIODS > (1 << UP_W)) begin : g_bad_up
        $error("UP_PERIODS does not fit the raise counter");
    end
    if (DOWN_PERIODS < 1 || DOWN_PERIODS > (1 << DN_W)) begin : g_bad_dn
        $error("DOWN_PERIODS does not fit the lower counter");
    end
    if (GAIN_W != $bits(GAIN_MAX)) begin : g_bad_gain
        $error("GAIN_MAX width differs from GAIN_W");
    end

    // All state of the block
    typedef struct packed {
        logic [REL_LEN-1:0]  rel_sync;  // Reset release stages
        logic [SYNC_LEN-1:0] car_sync;  // Carrier level stages
        logic [SYNC_LEN-1:0] tick_sync; // Period tick stages
        logic [SYNC_LEN-1:0] amp_sync;  // Amplitude compare stages
        logic                tick_prev; // Edge detector history
        mode_e               mode;
        logic [PRE_W-1:0]    pre_cnt;
        logic [UP_W-1:0]     up_cnt;
        logic [DN_W-1:0]     dn_cnt;
        logic [GAIN_W-1:0]   gain;
        logic                data_n;
        logic                wake_n;
        logic                agc_en;
        logic                pdown;
    } state_s;

    state_s st_q;
    state_s st_d;
    logic   any_rst;  // Merged asynchronous reset
    logic   run;      // Release synchroniser done
    logic   car;      // Synchronised carrier present
    logic   tick;     // One clock per counted period
    logic   amp;      // Synchronised amplitude above reference
    logic   pre_done;
    logic   up_done;
    logic   dn_done;

    // Pin reset or low supply clears all state at once
    assign any_rst = reset | ~supply_good;

    // Synchronised views of the carrier-side inputs
    assign run      = st_q.rel_sync[REL_LEN-1];
    assign car      = st_q.car_sync[SYNC_LEN-1];
    assign amp      = st_q.amp_sync[SYNC_LEN-1];
    assign tick     = st_q.tick_sync[SYNC_LEN-1] & ~st_q.tick_prev;

    // Terminal count decodes
    assign pre_done = (st_q.pre_cnt == PRE_LAST);
    assign up_done  = (st_q.up_cnt == UP_LAST);
    assign dn_done  = (st_q.dn_cnt == DN_LAST);

    // Next state: synchronisers, mode sequence and gain regulation
    always_comb begin
        st_d           = st_q;
        // Synchronisers shift every clock; only the last stage is read
        st_d.rel_sync  = {st_q.rel_sync[REL_LEN-2:0], 1'b1};
        st_d.car_sync  = {st_q.car_sync[SYNC_LEN-2:0], carrier_in};
        st_d.tick_sync = {st_q.tick_sync[SYNC_LEN-2:0], period_tick};
        st_d.amp_sync  = {st_q.amp_sync[SYNC_LEN-2:0], amp_above_ref};
        st_d.tick_prev = st_q.tick_sync[SYNC_LEN-1];
        // Power-down ends on the first edge after release
        st_d.pdown     = 1'b0;
        if (run) begin
            unique case (st_q.mode)
                // Standby listen: count unbroken carrier periods
                ST_LISTEN: begin
                    st_d.gain   = GAIN_MAX;
                    st_d.agc_en = 1'b0;
                    st_d.data_n = 1'b1;
                    st_d.wake_n = 1'b1;
                    if (!car) begin
                        // Any break restarts the count
                        st_d.pre_cnt = '0;
                    end else if (tick) begin
                        if (pre_done) begin
                            st_d.pre_cnt = '0;
                            st_d.mode    = ST_ACTIVE;
                            st_d.agc_en  = 1'b1;
                        end else begin
                            st_d.pre_cnt = st_q.pre_cnt + PRE_STEP;
                        end
                    end
                end
                // Preamble seen: outputs idle until the start gap
                ST_ACTIVE: begin
                    st_d.wake_n = 1'b1;
                    st_d.data_n = 1'b1;
                    if (!car) begin
                        st_d.mode   = ST_AWAKE;
                        st_d.wake_n = 1'b0;
                        st_d.data_n = car;
                    end
                end
                // Awake: no way back but reset
                ST_AWAKE: begin
                    st_d.mode   = ST_AWAKE;
                    st_d.wake_n = 1'b0;
                    st_d.data_n = car;
                end
                // Unused code falls back to listening
                default: begin
                    st_d.mode = ST_LISTEN;
                end
            endcase
            // Gain regulation, one decision per counted period
            if (st_q.agc_en && tick) begin
                if (amp) begin
                    // Above reference: lower gain after the down count
                    st_d.up_cnt = '0;
                    if (dn_done) begin
                        st_d.dn_cnt = '0;
                        if (st_q.gain != GAIN_MIN) begin
                            st_d.gain = st_q.gain - GAIN_STEP;
                        end
                    end else begin
                        st_d.dn_cnt = st_q.dn_cnt + DN_STEP;
                    end
                end else begin
                    // Below reference: raise gain after the up count
                    st_d.dn_cnt = '0;
                    if (up_done) begin
                        st_d.up_cnt = '0;
                        if (st_q.gain != GAIN_MAX) begin
                            st_d.gain = st_q.gain + GAIN_STEP;
                        end
                    end else begin
                        st_d.up_cnt = st_q.up_cnt + UP_STEP;
                    end
                end
            end
        end
    end

    // State register; reset loads standby values
    always_ff @(posedge sys_clk or posedge any_rst) begin
        if (any_rst) begin
            st_q          <= '0;
            st_q.mode     <= ST_LISTEN;
            st_q.gain     <= GAIN_MAX;
            st_q.data_n   <= 1'b1;
            st_q.wake_n   <= 1'b1;
            st_q.pdown    <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign data_n             = st_q.data_n;
    assign wake_request_out_n = st_q.wake_n;
    assign gain_regulator_en  = st_q.agc_en;
    assign gain_step          = st_q.gain;
    assign power_down         = st_q.pdown;
endmodule
`default_nettype wire

/* File: dv/wake_ctrl_props.sv */
// Port checker for wake_ctrl.
// Assumes one sys_clk domain; bound to every wake_ctrl.
`timescale 1ns/1ns
`default_nettype none
module wake_ctrl_props
    import wake_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic              supply_good,
    input wire logic              carrier_in,
    input wire logic              data_n,
    input wire logic              wake_request_out_n,
    input wire logic              gain_regulator_en,
    input wire logic [GAIN_W-1:0] gain_step,
    input wire logic              power_down
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset || !supply_good);
    sequence s_wake; $fell(wake_request_out_n); endsequence
    // Release, standby and wake properties
    property p_rel; $fell(reset) |-> power_down && data_n && wake_request_out_n; endproperty
    a_rel: assert property (p_rel) else $error("not idle at release");
    property p_pd; $fell(reset) |=> !power_down; endproperty
    a_pd: assert property (p_pd) else $error("power down held");
    property p_idle; !gain_regulator_en |-> gain_step == GAIN_MAX && wake_request_out_n; endproperty
    a_idle: assert property (p_idle) else $error("listen state bad");
    property p_keep; gain_regulator_en |=> gain_regulator_en; endproperty
    a_keep: assert property (p_keep) else $error("left active");
    property p_wake; !wake_request_out_n |=> !wake_request_out_n; endproperty
    a_wake: assert property (p_wake) else $error("wake released");
    property p_gap; s_wake |-> gain_regulator_en; endproperty
    a_gap: assert property (p_gap) else $error("wake before preamble");
    property p_fol; !wake_request_out_n && $rose(carrier_in) |-> ##[1:6] data_n; endproperty
    a_fol: assert property (p_fol) else $error("data not following");
    property p_gapd; !wake_request_out_n && $fell(carrier_in) |-> ##[1:6] !data_n; endproperty
    a_gapd: assert property (p_gapd) else $error("data not low in gap");
    property p_pre; $rose(gain_regulator_en) |-> $past(carrier_in, 3); endproperty
    a_pre: assert property (p_pre) else $error("regulation without carrier");
endmodule
bind wake_ctrl wake_ctrl_props u_props (.sys_clk(sys_clk), .reset(reset),
    .supply_good(supply_good), .carrier_in(carrier_in), .data_n(data_n),
    .wake_request_out_n(wake_request_out_n), .gain_regulator_en(gain_regulator_en),
    .gain_step(gain_step), .power_down(power_down));
`default_nettype wire

/* File: dv/host_model.sv */
// Host model: holds reset 4 cycles at start, pulses it on rearm.
// Assumes rearm is a request of one or two cycles from the bench.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic sys_clk,
    input  wire logic rearm,
    output var  logic reset
);
    logic [2:0] hold_q = 3'h4;
    // Reset hold count, restarted by rearm
    always @(posedge sys_clk) begin
        if (rearm) begin
            hold_q <= 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    assign reset = (hold_q != 3'h0);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Bench for wake_ctrl with the host model driving reset.
// Assumes PREAMBLE_LEN of 4; amplitude input held low.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import wake_pkg::*;
    logic sys_clk = 0, supply_good = 0, carrier_in = 0, period_tick = 0, rearm = 0;
    logic reset, data_n, wake_request_out_n, gain_regulator_en, power_down;
    logic [GAIN_W-1:0] gain_step;
    int miscompares = 0, samples_checked = 0;
    logic [4:0] rows [3] = '{5'h0d, 5'h12, 5'h1a}; // Ticks, gain on, wake
    always #10 sys_clk = ~sys_clk;
    host_model u_host (.sys_clk(sys_clk), .rearm(rearm), .reset(reset));
    wake_ctrl #(.PREAMBLE_LEN(4)) u_dut (.sys_clk(sys_clk), .reset(reset),
        .supply_good(supply_good), .carrier_in(carrier_in), .period_tick(period_tick),
        .amp_above_ref(1'b0), .data_n(data_n), .wake_request_out_n(wake_request_out_n),
        .gain_regulator_en(gain_regulator_en), .gain_step(gain_step), .power_down(power_down));
    task chk(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %b exp %b", $time, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task ticks(input int n);
        repeat (n) begin
            period_tick <= 1;
            wt(3);
            period_tick <= 0;
            wt(3);
        end
    endtask
    task results;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Rows: short and full preambles, then the hand cases
    initial begin
        wt(2);
        supply_good <= 1;
        foreach (rows[i]) begin
            rearm <= 1;
            wt(1);
            rearm <= 0;
            carrier_in <= 1;
            wt(8);
            ticks(rows[i][4:2]);
            wt(6);
            chk({gain_regulator_en, wake_request_out_n}, {rows[i][1], 1'b1});
            carrier_in <= 0;
            wt(8);
            chk({gain_regulator_en, wake_request_out_n}, rows[i][1:0]);
        end
        carrier_in <= 1;
        wt(8);
        chk({wake_request_out_n, data_n}, 2'b01);
        chk({gain_step == GAIN_MAX, gain_regulator_en}, 2'b11);
        carrier_in <= 0;
        wt(8);
        chk({wake_request_out_n, data_n}, 2'b00);
        rearm <= 1;
        wt(2);
        chk({power_down, wake_request_out_n}, 2'b11);
        rearm <= 0;
        wt(8);
        chk({gain_regulator_en, wake_request_out_n}, 2'b01);
        supply_good <= 0;
        wt(2);
        chk({power_down, data_n}, 2'b11);
        supply_good <= 1;
        wt(8);
        chk({power_down, wake_request_out_n}, 2'b01);
        results();
    end
endmodule
`default_nettype wire
